// ### design/sac_top.sv
// Digital control for the four-channel 10-bit successive-approximation converter
// Functional notes
// - Result is 10 bits; one of four inputs is converted each time.
// - Hardware start begins on the chosen trigger edge: rising, falling or both.
// - Software start begins as soon as mode is written with conversion enabled.
// - Hardware start stops after each conversion and raises the end request.
// - Software start repeats back to back, raising the end request each time.
// - Approximation resolves MSB first; the finished value goes to the result.
// - Result word is 16 bits, left-justified, lower six bits always zero.
// - Upper eight result bits in the high byte, lower two atop the low byte.
// - Reset clears the result register to zero.
// - Writing the channel register leaves the end flag alone.
// - Sampling lasts about one tenth of the conversion time.
// - Mode bit 7 enables (0 stops at once); bit 6 picks hardware start.
// - Edge field: 00 none, 01 falling, 10 rising, 11 both.
// ************************************************************
// Design notes
// ************************************************************
// Register port: one-cycle strobes, read data stand only in the cycle after the read strobe.
// Map: result word, mode byte, channel byte, and a status byte of our own choosing.
// Status read: bit 0 is the end flag, bit 1 is high whenever the sequencer is not idle.
// Status write: a one in bit 0 clears the end flag; a completion in that cycle still sets it.
// Mode byte: enable, hardware start, three time-select bits, two edge bits, one unused bit.
// Prohibited time codes fall back to the longest setting, so a bad write stays slow, not fast.
// Step length is about nine hundredths of the total; sampling takes whatever ten steps leave.
// Writing mode or channel restarts the sequencer from the top, even with equal data.
// A mode or channel write in the completion cycle wins: no result load, no request and no flag that cycle.
// The result is kept across such writes rather than left undefined, a safe superset.
// Trigger and comparator come from outside the clock domain and pass two flops first.
// The trigger edge enters sampling two to three clocks after the pin moves; short pulses are lost.
// Triggers that arrive while sampling or converting are ignored, never queued.
// The comparator is looked at two clocks late, so every step must last three clocks or more.
// Hazard: the shortest setting gives four clocks per step, which still leaves a clock spare.
// Limitation: the low six result bits are never stored, only padded on the way out.
// Limitation: only the full 16-bit word is mapped; the high byte alone reads as zero.
// The request output is a one-cycle pulse; the flag is the sticky copy for polling.
// All outputs come straight from the state flops, so nothing combinational reaches a pin.
`timescale 1ns/1ns
`default_nettype none

module sac_top (
    input wire logic clk,
    input wire logic nrst,
    input wire sac_pkg::sac_bus_req_type bus_req,
    output logic [15:0] bus_rdata,
    input wire logic comparator_hi,
    input wire logic external_conv_trigger,
    output sac_pkg::sac_afe_type afe_ctrl,
    output logic conv_end_irq,
    output logic conv_end_irq_flag
);

    // ************************************************************
    // State and decoded fields
    // ************************************************************
    sac_pkg::sac_regs_type r;
    sac_pkg::sac_regs_type n;
    logic conversion_enable_bit;
    logic hw_start_select_bit;
    logic [2:0] time_sel;
    sac_pkg::sac_edge_type edge_sel;
    logic trig_hit;

    assign conversion_enable_bit = r.mode[sac_pkg::SAC_MODE_EN_BIT];
    assign hw_start_select_bit = r.mode[sac_pkg::SAC_MODE_HW_BIT];
    assign time_sel = r.mode[sac_pkg::SAC_MODE_TSEL_LSB +: 3];
    assign edge_sel = sac_pkg::sac_edge_type'(r.mode[sac_pkg::SAC_MODE_EDGE_LSB +: 2]);

    // Edge seen on the synchronised trigger; only the second and third stages are looked at
    always_comb begin
        trig_hit = 1'b0;
        case (edge_sel)
            sac_pkg::SAC_EDGE_FALL: trig_hit = !r.trg_s2 && r.trg_s3;
            sac_pkg::SAC_EDGE_RISE: trig_hit = r.trg_s2 && !r.trg_s3;
            sac_pkg::SAC_EDGE_BOTH: trig_hit = r.trg_s2 != r.trg_s3;
            default: trig_hit = 1'b0; // No edge detection
        endcase
    end

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        logic [9:0] dec;
        logic set_flag;
        logic clr_flag;
        logic restart;
        logic [7:0] new_mode;
        dec = r.approx;
        set_flag = 1'b0;
        clr_flag = 1'b0;
        restart = 1'b0;
        new_mode = r.mode;
        n = r;
        n.irq = 1'b0;
        n.rdata = 16'h0000;
        // Two-flop synchronisers for the pin and the comparator
        n.trg_s1 = external_conv_trigger;
        n.trg_s2 = r.trg_s1;
        n.trg_s3 = r.trg_s2;
        n.cmp_s1 = comparator_hi;
        n.cmp_s2 = r.cmp_s1;

        // Sequencer; triggers outside the waiting state are ignored
        case (r.state)
            sac_pkg::SAC_ST_IDLE: begin
                n.sample_en = 1'b0;
            end
            sac_pkg::SAC_ST_WAIT: begin
                if (trig_hit) begin
                    n.state = sac_pkg::SAC_ST_SAMPLE;
                    n.sample_en = 1'b1;
                    n.cnt = sac_pkg::sac_samp_cyc(time_sel) - 8'h01;
                end
            end
            sac_pkg::SAC_ST_SAMPLE: begin
                if (r.cnt == 8'h00) begin
                    n.state = sac_pkg::SAC_ST_CONVERT;
                    n.sample_en = 1'b0;
                    n.approx = sac_pkg::SAC_SAR_MSB;
                    n.bit_idx = sac_pkg::SAC_SAR_TOP_IDX;
                    n.cnt = sac_pkg::sac_step_cyc(time_sel) - 8'h01;
                end else begin
                    n.cnt = r.cnt - 8'h01;
                end
            end
            sac_pkg::SAC_ST_CONVERT: begin
                if (r.cnt == 8'h00) begin
                    // Comparator low means the tap is above the input: drop the trial bit
                    if (!r.cmp_s2) begin
                        dec[r.bit_idx] = 1'b0;
                    end
                    if (r.bit_idx == 4'h0) begin
                        n.approx = dec;
                        n.result = dec;
                        n.irq = 1'b1;
                        set_flag = 1'b1;
                        if (hw_start_select_bit) begin
                            n.state = sac_pkg::SAC_ST_WAIT;
                        end else begin
                            n.state = sac_pkg::SAC_ST_SAMPLE;
                            n.sample_en = 1'b1;
                            n.cnt = sac_pkg::sac_samp_cyc(time_sel) - 8'h01;
                        end
                    end else begin
                        dec[r.bit_idx - 4'h1] = 1'b1;
                        n.approx = dec;
                        n.bit_idx = r.bit_idx - 4'h1;
                        n.cnt = sac_pkg::sac_step_cyc(time_sel) - 8'h01;
                    end
                end else begin
                    n.cnt = r.cnt - 8'h01;
                end
            end
            default: begin
                n.state = sac_pkg::SAC_ST_IDLE;
                n.sample_en = 1'b0;
            end
        endcase

        // Mode and channel writes beat a completing conversion: no result load and no request then
        if (bus_req.wr) begin
            case (bus_req.addr)
                sac_pkg::SAC_ADDR_MODE: begin
                    new_mode = bus_req.wdata[7:0];
                    n.mode = new_mode;
                    restart = 1'b1;
                end
                sac_pkg::SAC_ADDR_CHAN: begin
                    n.chan = bus_req.wdata[1:0];
                    restart = 1'b1; // Flag untouched here
                end
                sac_pkg::SAC_ADDR_STATUS: begin
                    clr_flag = bus_req.wdata[sac_pkg::SAC_STAT_FLAG_BIT];
                end
                default: begin
                end
            endcase
        end
        if (restart) begin
            n.irq = 1'b0;
            n.result = r.result;
            set_flag = 1'b0;
            n.approx = r.approx;
            if (!new_mode[sac_pkg::SAC_MODE_EN_BIT]) begin
                n.state = sac_pkg::SAC_ST_IDLE;
                n.sample_en = 1'b0;
            end else if (new_mode[sac_pkg::SAC_MODE_HW_BIT]) begin
                n.state = sac_pkg::SAC_ST_WAIT;
                n.sample_en = 1'b0;
            end else begin
                n.state = sac_pkg::SAC_ST_SAMPLE;
                n.sample_en = 1'b1;
                n.cnt = sac_pkg::sac_samp_cyc(new_mode[sac_pkg::SAC_MODE_TSEL_LSB +: 3]) - 8'h01;
            end
        end
        // Hardware set wins over a software clear in the same cycle
        n.flag = set_flag || (r.flag && !clr_flag);

        // Read data stand only in the cycle after the strobe
        if (bus_req.rd) begin
            case (bus_req.addr)
                sac_pkg::SAC_ADDR_RESULT: n.rdata = {r.result, 6'h00};
                sac_pkg::SAC_ADDR_MODE: n.rdata = {8'h00, r.mode};
                sac_pkg::SAC_ADDR_CHAN: n.rdata = {14'h0000, r.chan};
                sac_pkg::SAC_ADDR_STATUS: n.rdata = {14'h0000, r.state != sac_pkg::SAC_ST_IDLE, r.flag};
                default: n.rdata = 16'h0000;
            endcase
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r <= sac_pkg::SAC_REGS_RST;
        end else begin
            r <= n;
        end
    end

    // Outputs straight from the state flops
    assign bus_rdata = r.rdata;
    // One driver for the whole carrier keeps the struct a single variable
    assign afe_ctrl = '{
        channel: r.chan,
        sample_en: r.sample_en,
        tap_code: r.approx};
    assign conv_end_irq = r.irq;
    assign conv_end_irq_flag = r.flag;

    // ************************************************************
    // Timing summary
    // ************************************************************
    // Software start: the write edge enters sampling; the request follows one total later.
    // Repeat: the completion edge re-enters sampling at once, so the period is one total.
    // Hardware start: the trigger edge on the synced stage enters sampling one clock later.
    // After a hardware conversion the sequencer waits again with sampling off.
    // Stop: a mode write with enable low goes idle at the write edge, mid-step or not.
    // Tap code changes only at step ends, so the analog side sees a steady level per step.
    // The held input is captured only while sampling, so all ten steps use one value.
    // Read data return to zero after their cycle, so a stale word is never seen twice.
    // Reset leaves every output low; the first request comes no sooner than one total after an enabling mode write.
    // Flag: the hardware set wins over a software clear, so no completion is lost to a clear.
    // Channel writes leave the flag alone; software clears it only through status bit 0.
    // Hazard: a flag seen just after a channel write may belong to the old channel.
    // Trade-off: no interrupt logic here; the pulse and flag go to the system controller.
    // Trade-off: counters are eight bits, wide enough for the longest sampling and step.

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    logic wr_mode;
    logic wr_chan;
    assign wr_mode = bus_req.wr && bus_req.addr == sac_pkg::SAC_ADDR_MODE;
    assign wr_chan = bus_req.wr && bus_req.addr == sac_pkg::SAC_ADDR_CHAN;

    result_pad_zero_a: assert property (
        bus_req.rd && bus_req.addr == sac_pkg::SAC_ADDR_RESULT |=> bus_rdata[5:0] == 6'h00
            && bus_rdata[15:6] == $past(r.result))
        else $error("result read wrong or low bits set");

    sw_start_now_a: assert property (
        wr_mode && bus_req.wdata[7] && !bus_req.wdata[6] |=> r.state == sac_pkg::SAC_ST_SAMPLE && afe_ctrl.sample_en)
        else $error("software start did not begin sampling");

    stop_now_a: assert property (
        wr_mode && !bus_req.wdata[7] |=> r.state == sac_pkg::SAC_ST_IDLE && !afe_ctrl.sample_en)
        else $error("clearing enable did not stop at once");

    trig_start_a: assert property (
        r.state == sac_pkg::SAC_ST_WAIT && trig_hit && !bus_req.wr |=> r.state == sac_pkg::SAC_ST_SAMPLE)
        else $error("trigger edge did not start a conversion");

    hw_stop_after_a: assert property (
        conv_end_irq && hw_start_select_bit |-> r.state == sac_pkg::SAC_ST_WAIT && !afe_ctrl.sample_en)
        else $error("hardware start did not stop after completion");

    sw_repeat_a: assert property (
        conv_end_irq && !hw_start_select_bit |-> r.state == sac_pkg::SAC_ST_SAMPLE && conv_end_irq_flag)
        else $error("software start did not repeat");

    result_load_a: assert property (
        conv_end_irq |-> r.result == r.approx && $past(r.state) == sac_pkg::SAC_ST_CONVERT
            && $past(r.bit_idx) == 4'h0)
        else $error("result not loaded from final approximation");

    msb_first_a: assert property (
        $rose(r.state == sac_pkg::SAC_ST_CONVERT) |-> afe_ctrl.tap_code == 10'h200 && r.bit_idx == 4'h9)
        else $error("approximation did not start at the top bit");

    chan_keep_flag_a: assert property (
        wr_chan && conv_end_irq_flag |=> conv_end_irq_flag)
        else $error("channel write cleared the end flag");

    sample_len_a: assert property (
        $rose(afe_ctrl.sample_en) && time_sel == 3'h0 |-> (afe_ctrl.sample_en || $past(bus_req.wr))[*8])
        else $error("sampling phase cut short");

    // The end request lasts exactly one cycle
    irq_pulse_a: assert property (
        conv_end_irq |=> !conv_end_irq)
        else $error("end request longer than one cycle");

    // Every end request comes with the sticky flag
    flag_with_irq_a: assert property (
        conv_end_irq |-> conv_end_irq_flag)
        else $error("end request without the flag");

    // The selected input follows a channel write at once
    chan_follow_a: assert property (
        wr_chan |=> afe_ctrl.channel == $past(bus_req.wdata[1:0]))
        else $error("channel output did not follow the write");

    // Without a read strobe the read data fall back to zero
    rdata_quiet_a: assert property (
        !bus_req.rd |=> bus_rdata == 16'h0000)
        else $error("read data stood without a read");

    // An idle sequencer never samples
    idle_quiet_a: assert property (
        r.state == sac_pkg::SAC_ST_IDLE |-> !afe_ctrl.sample_en)
        else $error("sampling while idle");

    sw_done_c: cover property (conv_end_irq && !hw_start_select_bit);
    hw_done_c: cover property (conv_end_irq && hw_start_select_bit);
    chan_abort_c: cover property (r.state == sac_pkg::SAC_ST_CONVERT && wr_chan);
    both_edge_c: cover property (trig_hit && edge_sel == sac_pkg::SAC_EDGE_BOTH && !r.trg_s2);
    mode_abort_c: cover property (r.state == sac_pkg::SAC_ST_CONVERT && wr_mode);

endmodule : sac_top

`default_nettype wire

// ### design/sac_pkg.sv
// Package for the APPROXIMATION_REG converter control block: map, layouts, reset values, timing and types
package sac_pkg;

    // ************************************************************
    // Register map (byte addresses on the plain register port)
    // ************************************************************
    localparam logic [15:0] SAC_ADDR_RESULT = 16'hFF16;
    localparam logic [15:0] SAC_ADDR_MODE = 16'hFF80;
    localparam logic [15:0] SAC_ADDR_CHAN = 16'hFF81;
    localparam logic [15:0] SAC_ADDR_STATUS = 16'hFF82;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int SAC_MODE_EN_BIT = 7;
    localparam int SAC_MODE_HW_BIT = 6;
    localparam int SAC_MODE_TSEL_LSB = 3;
    localparam int SAC_MODE_EDGE_LSB = 1;
    localparam int SAC_STAT_FLAG_BIT = 0;
    localparam int SAC_STAT_BUSY_BIT = 1;
    localparam int SAC_RESULT_PAD = 6;

    // ************************************************************
    // Values after reset, and the trial start of each approximation
    // ************************************************************
    localparam logic [7:0] SAC_MODE_RST = 8'h00;
    localparam logic [1:0] SAC_CHAN_RST = 2'h0;
    localparam logic [9:0] SAC_RESULT_RST = 10'h000;
    localparam logic [9:0] SAC_SAR_MSB = 10'h200;
    localparam logic [3:0] SAC_SAR_TOP_IDX = 4'h9;

    // ************************************************************
    // Conversion time in clocks per setting (others fall back to the longest)
    // ************************************************************
    localparam int SAC_CONV_CLK_0 = 144;
    localparam int SAC_CONV_CLK_1 = 120;
    localparam int SAC_CONV_CLK_2 = 96;
    localparam int SAC_CONV_CLK_4 = 72;
    localparam int SAC_CONV_CLK_5 = 60;
    localparam int SAC_CONV_CLK_6 = 48;
    localparam int SAC_BITS = 10;

    typedef enum logic [1:0] {
        SAC_EDGE_NONE = 2'h0,
        SAC_EDGE_FALL = 2'h1,
        SAC_EDGE_RISE = 2'h2,
        SAC_EDGE_BOTH = 2'h3
    } sac_edge_type;

    // Gray along idle -> wait -> sample -> convert -> sample
    typedef enum logic [1:0] {
        SAC_ST_IDLE = 2'h0,
        SAC_ST_WAIT = 2'h1,
        SAC_ST_SAMPLE = 2'h3,
        SAC_ST_CONVERT = 2'h2
    } sac_state_type;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } sac_bus_req_type;

    typedef struct packed {
        logic [1:0] channel;
        logic sample_en;
        logic [9:0] tap_code;
    } sac_afe_type;

    typedef struct packed {
        sac_state_type state;
        logic [7:0] mode;
        logic [1:0] chan;
        logic flag;
        logic [7:0] cnt;
        logic [3:0] bit_idx;
        logic [9:0] approx;
        logic [9:0] result;
        logic [15:0] rdata;
        logic irq;
        logic sample_en;
        logic trg_s1;
        logic trg_s2;
        logic trg_s3;
        logic cmp_s1;
        logic cmp_s2;
    } sac_regs_type;

    localparam sac_regs_type SAC_REGS_RST = '{state: SAC_ST_IDLE, mode: SAC_MODE_RST, chan: SAC_CHAN_RST,
        result: SAC_RESULT_RST, default: '0};

    // Total conversion clocks for a time setting
    function automatic int sac_total_cyc(input logic [2:0] sel);
        int t;
        t = SAC_CONV_CLK_0;
        case (sel)
            3'h1: t = SAC_CONV_CLK_1;
            3'h2: t = SAC_CONV_CLK_2;
            3'h4: t = SAC_CONV_CLK_4;
            3'h5: t = SAC_CONV_CLK_5;
            3'h6: t = SAC_CONV_CLK_6;
            default: t = SAC_CONV_CLK_0;
        endcase
        return t;
    endfunction : sac_total_cyc

    // Clocks per bit step: nine tenths of the total shared by ten bits, rounded
    function automatic logic [7:0] sac_step_cyc(input logic [2:0] sel);
        return 8'((sac_total_cyc(sel) * 9 + 50) / 100);
    endfunction : sac_step_cyc

    // Sampling takes what the ten steps leave, about one tenth
    function automatic logic [7:0] sac_samp_cyc(input logic [2:0] sel);
        return 8'(sac_total_cyc(sel) - SAC_BITS * int'(sac_step_cyc(sel)));
    endfunction : sac_samp_cyc

endpackage : sac_pkg

// ### dv/sac_afe_model.sv
// Behavioural comparator, sample-and-hold and trigger pin facing the converter control
`timescale 1ns/1ns
`default_nettype none

module sac_afe_model (
    input wire logic clk,
    input wire sac_pkg::sac_afe_type afe_ctrl,
    input wire logic [39:0] level_codes,
    input wire logic trig_level,
    output logic comparator_hi,
    output logic external_conv_trigger
);
    logic [9:0] held = 10'h000;

    // ************************************************************
    // Sample and hold
    // ************************************************************
    // Input is captured only while sampling, so the ten steps all compare one held value
    always @(posedge clk) begin
        if (afe_ctrl.sample_en === 1'b1) begin
            held <= level_codes[afe_ctrl.channel * 10 +: 10];
        end
    end

    // Comparator: high while the held input is at or above the tap
    assign comparator_hi = (held >= afe_ctrl.tap_code);

    // Pin moves just after an edge, never on it
    initial external_conv_trigger = 1'b0;
    always @(posedge clk) begin
        external_conv_trigger <= trig_level;
    end
endmodule : sac_afe_model
`default_nettype wire

// ### dv/tb_top.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ns
`default_nettype none

module tb_top;
    logic clk;
    logic nrst;
    sac_pkg::sac_bus_req_type bus_req;
    logic [15:0] bus_rdata;
    logic comparator_hi;
    logic external_conv_trigger;
    sac_pkg::sac_afe_type afe_ctrl;
    logic conv_end_irq;
    logic conv_end_irq_flag;
    logic trig_level;
    logic [39:0] level_codes;
    logic [15:0] rd_val;
    int failures;
    int n_compared;
    int cyc;
    int t0;
    int n_irq;
    int n_samp;
    int total;
    int conv_clk [8] = '{144, 120, 96, 144, 72, 60, 48, 144};

    sac_top u_dut (.clk(clk), .nrst(nrst), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .comparator_hi(comparator_hi), .external_conv_trigger(external_conv_trigger),
        .afe_ctrl(afe_ctrl), .conv_end_irq(conv_end_irq), .conv_end_irq_flag(conv_end_irq_flag));
    sac_afe_model u_afe (.clk(clk), .afe_ctrl(afe_ctrl), .level_codes(level_codes),
        .trig_level(trig_level), .comparator_hi(comparator_hi),
        .external_conv_trigger(external_conv_trigger));

    // ************************************************************
    // Clock and cycle count
    // ************************************************************
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // One-cycle write strobe; returns just after the taking edge has landed
    task automatic bus_wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        bus_req.addr <= a;
        bus_req.wdata <= d;
        bus_req.wr <= 1'b1;
        @(posedge clk);
        bus_req.wr <= 1'b0;
        #1;
    endtask : bus_wr

    // Read data stand only in the cycle after the strobe, so sample right there
    task automatic bus_rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge clk);
        bus_req.addr <= a;
        bus_req.rd <= 1'b1;
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1;
        d = bus_rdata;
    endtask : bus_rd

    // Bounded wait for the end pulse, counting sampling cycles on the way
    task automatic wait_irq(input int lim);
        // The write edge already entered sampling, so that cycle counts too
        n_samp = (afe_ctrl.sample_en === 1'b1) ? 1 : 0;
        repeat (lim) begin
            @(posedge clk);
            #1;
            if (conv_end_irq === 1'b1) return;
            if (afe_ctrl.sample_en === 1'b1) n_samp++;
        end
    endtask : wait_irq

    task automatic count_irq(input int lim);
        n_irq = 0;
        repeat (lim) begin
            @(posedge clk);
            #1;
            if (conv_end_irq === 1'b1) n_irq++;
        end
    endtask : count_irq

    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test

    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        nrst = 1'b0;
        bus_req = '0;
        trig_level = 1'b0;
        level_codes = {10'h155, 10'h000, 10'h3FF, 10'h2A5};
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        bus_rd(sac_pkg::SAC_ADDR_RESULT, rd_val);
        chk("result after reset", 16'h0000, rd_val);
        @(posedge clk);
        #1;
        chk("read data after its cycle", 16'h0000, bus_rdata);
        // Every time setting, cycling through all four channels in software start
        for (int sel = 0; sel < 8; sel++) begin
            total = conv_clk[sel];
            bus_wr(sac_pkg::SAC_ADDR_CHAN, 16'(sel % 4));
            bus_wr(sac_pkg::SAC_ADDR_MODE, 16'h0080 | 16'(sel << 3));
            t0 = cyc;
            wait_irq(400);
            chk("first end delay", 16'(total), 16'(cyc - t0));
            chk("sampling length", 16'(total - 10 * ((total * 9 + 50) / 100)), 16'(n_samp));
            chk("end flag", 16'h0001, 16'(conv_end_irq_flag));
            t0 = cyc;
            @(posedge clk);
            #1;
            chk("end pulse width", 16'h0000, 16'(conv_end_irq));
            wait_irq(400); // First result discarded
            chk("repeat period", 16'(total), 16'(cyc - t0));
            bus_rd(sac_pkg::SAC_ADDR_RESULT, rd_val); // Read while enabled
            chk("result word", {level_codes[(sel % 4) * 10 +: 10], 6'h00}, rd_val);
            chk("channel out", 16'(sel % 4), 16'(afe_ctrl.channel));
        end
        // Stop at once, then the read-only result and an unmapped byte
        bus_wr(sac_pkg::SAC_ADDR_MODE, 16'h0000);
        count_irq(300);
        chk("ends after stop", 16'h0000, 16'(n_irq));
        bus_rd(sac_pkg::SAC_ADDR_STATUS, rd_val);
        chk("status after stop", 16'h0001, rd_val);
        bus_wr(sac_pkg::SAC_ADDR_RESULT, 16'hFFFF);
        bus_rd(sac_pkg::SAC_ADDR_RESULT, rd_val);
        chk("result kept on write", {level_codes[39:30], 6'h00}, rd_val);
        bus_rd(16'hFF17, rd_val);
        chk("high byte alone", 16'h0000, rd_val);
        // Hardware start for each edge code, one rising then one falling trigger
        for (int e = 0; e < 4; e++) begin
            bus_wr(sac_pkg::SAC_ADDR_MODE, 16'h00C0 | 16'(e << 1));
            repeat (5) @(posedge clk);
            trig_level <= 1'b1;
            count_irq(350);
            chk("ends on rising", 16'(e >> 1), 16'(n_irq));
            chk("idle while waiting", 16'h0000, 16'(afe_ctrl.sample_en));
            trig_level <= 1'b0;
            count_irq(350);
            chk("ends on falling", 16'(e & 1), 16'(n_irq));
        end
        // Channel rewrite keeps the flag; only the status write clears it
        bus_wr(sac_pkg::SAC_ADDR_CHAN, 16'h0001);
        chk("flag after channel write", 16'h0001, 16'(conv_end_irq_flag));
        bus_wr(sac_pkg::SAC_ADDR_STATUS, 16'h0001);
        bus_rd(sac_pkg::SAC_ADDR_STATUS, rd_val);
        chk("status after clear", 16'h0002, rd_val); // Still waiting for a trigger
        stop_test();
    end

    // Tests need under 10000 cycles; a hang ends the run as a mismatch
    initial begin
        repeat (30000) @(posedge clk);
        failures++;
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
